/* File: shared/clt_consts.svh */
// offsets, field positions, reset values and timing counts
`ifndef CLT_CONSTS_SVH
`define CLT_CONSTS_SVH

`define CLT_CLK_NS       25
`define CLT_TICK_NS      1000
`define CLT_US_CYC       ((`CLT_TICK_NS + `CLT_CLK_NS - 1) / `CLT_CLK_NS)
`define CLT_TW           24
`define CLT_LW           26

`define CLT_OFS_CTRL     8'h00
`define CLT_OFS_CMD      8'h04
`define CLT_OFS_TRIG_W   8'h08
`define CLT_OFS_OFFSET   8'h0C
`define CLT_OFS_LIGHT_W  8'h10
`define CLT_OFS_MIN_SP   8'h14
`define CLT_OFS_PERIOD   8'h18
`define CLT_OFS_TOTAL    8'h1C
`define CLT_OFS_STATUS   8'h20
`define CLT_OFS_LOST     8'h24
`define CLT_OFS_CYC_LEN  8'h28

`define CLT_CTRL_ARM     0
`define CLT_CTRL_OVL     1
`define CLT_CTRL_CYC_EXT 2
`define CLT_CTRL_BEG_EXT 3
`define CLT_CTRL_END_CNT 4
`define CLT_CMD_BEGIN    0
`define CLT_CMD_HALT     1
`define CLT_CMD_CYCLE    2

`define CLT_RST_CTRL     5'h02
`define CLT_RST_TRIG_W   24'h00000A
`define CLT_RST_OFFSET   24'h000000
`define CLT_RST_LIGHT_W  24'h00000A
`define CLT_RST_MIN_SP   24'h000001
`define CLT_RST_PERIOD   24'h000001
`define CLT_RST_TOTAL    24'h000001

`define CLT_RESP_OKAY    2'h0
`define CLT_RESP_SLVERR  2'h2

`endif

/* File: shared/clt_pkg.sv */
// types shared by the camera light timer
`include "clt_consts.svh"
package clt_pkg;
  typedef struct packed {
    logic [`CLT_LW-1:0] cycle_len;
    logic [`CLT_LW-1:0] trig_delay;
    logic [`CLT_LW-1:0] trig_width;
    logic [`CLT_LW-1:0] light_delay;
    logic [`CLT_LW-1:0] light_width;
  } clt_tmg_t;

  typedef enum logic [2:0] {
    CLT_IDLE     = 3'h1,
    CLT_ACTIVE   = 3'h2,
    CLT_STOPPING = 3'h4
  } clt_seq_t;
endpackage

/* File: hdl/clt_axil_slave.sv */
// axi4-lite slave front end, one write and one read at a time
`include "clt_consts.svh"
module clt_axil_slave #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // axi4-lite
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // register side
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_err,
  output logic               rd_en,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_err
);
  logic aw_ok_ff;
  logic w_ok_ff;

  assign awready = !aw_ok_ff && !bvalid;
  assign wready  = !w_ok_ff && !bvalid;
  assign wr_en   = aw_ok_ff && w_ok_ff && !bvalid;
  assign arready = !rvalid;
  assign rd_en   = arvalid && arready;
  assign rd_addr = araddr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_ok_ff <= 1'b0;
      wr_addr  <= '0;
    end else if (awvalid && awready) begin
      aw_ok_ff <= 1'b1;
      wr_addr  <= awaddr;
    end else if (wr_en) begin
      aw_ok_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w_ok_ff <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_ok_ff <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_ok_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp  <= `CLT_RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? `CLT_RESP_SLVERR : `CLT_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `CLT_RESP_OKAY;
    end else if (rd_en) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_err ? `CLT_RESP_SLVERR : `CLT_RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // clt_axil_slave

/* File: hdl/clt_pulse_gen.sv */
// single cycle timer placing the trigger and strobe pulses
`include "clt_consts.svh"
module clt_pulse_gen (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // cycle control
  input  wire logic              start,
  input  wire clt_pkg::clt_tmg_t tmg_in,
  output logic                   busy,
  output logic                   cycle_end,
  // pulses
  output logic                   cam_trig,
  output logic                   light_strobe
);
  localparam int LW = `CLT_LW;
  localparam int US = `CLT_US_CYC;
  localparam int PW = $clog2(US);

  clt_pkg::clt_tmg_t tmg_ff;
  clt_pkg::clt_tmg_t cfg;
  logic [PW-1:0]     pre_ff;
  logic [PW-1:0]     nxt_pre;
  logic [LW-1:0]     t_ff;
  logic [LW-1:0]     nxt_t;
  logic              busy_ff;
  logic              nxt_busy;
  logic              trig_ff;
  logic              light_ff;
  logic              tick;
  logic [31:0]       run_cnt_ff;
  logic [31:0]       hi_cnt_ff;

  // microsecond tick within the running cycle
  assign tick      = pre_ff == PW'(US - 1);
  assign cycle_end = busy_ff && tick && t_ff == tmg_ff.cycle_len - LW'(1);
  assign busy         = busy_ff;
  assign cam_trig     = trig_ff;
  assign light_strobe = light_ff;

  always_comb begin
    cfg      = tmg_ff;
    nxt_pre  = pre_ff;
    nxt_t    = t_ff;
    nxt_busy = busy_ff;
    if (start) begin
      // restart wins over the end of the old cycle
      cfg      = tmg_in;
      nxt_pre  = '0;
      nxt_t    = '0;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      if (tick) begin
        nxt_pre = '0;
        if (cycle_end) begin
          nxt_busy = 1'b0;
        end else begin
          nxt_t = t_ff + LW'(1);
        end
      end else begin
        nxt_pre = pre_ff + PW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmg_ff  <= '0;
      pre_ff  <= '0;
      t_ff    <= '0;
      busy_ff <= 1'b0;
    end else begin
      tmg_ff  <= cfg;
      pre_ff  <= nxt_pre;
      t_ff    <= nxt_t;
      busy_ff <= nxt_busy;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trig_ff  <= 1'b0;
      light_ff <= 1'b0;
    end else begin
      trig_ff  <= nxt_busy && nxt_t >= cfg.trig_delay &&
                  nxt_t < cfg.trig_delay + cfg.trig_width;
      light_ff <= nxt_busy && nxt_t >= cfg.light_delay &&
                  nxt_t < cfg.light_delay + cfg.light_width;
    end
  end

  // helper counters for the checks below
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_cnt_ff <= '0;
      hi_cnt_ff  <= '0;
    end else begin
      run_cnt_ff <= start ? 32'h0 : run_cnt_ff + 32'h1;
      hi_cnt_ff  <= trig_ff ? hi_cnt_ff + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_trig_width;
    $fell(trig_ff) |->
      hi_cnt_ff == 32'(32'(tmg_ff.trig_width) * 32'(US));
  endproperty
  a_trig_width: assert property (p_trig_width)
    else $error("trigger pulse width wrong");

  property p_cycle_len;
    cycle_end |->
      run_cnt_ff == 32'(32'(tmg_ff.cycle_len) * 32'(US)) - 32'h1;
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("cycle length wrong");

  property p_trig_pos;
    $rose(trig_ff) |-> t_ff == tmg_ff.trig_delay && pre_ff == '0;
  endproperty
  a_trig_pos: assert property (p_trig_pos)
    else $error("trigger edge misplaced");

  property p_light_pos;
    $rose(light_ff) |-> t_ff == tmg_ff.light_delay && pre_ff == '0;
  endproperty
  a_light_pos: assert property (p_light_pos)
    else $error("strobe edge misplaced");

  property p_restart;
    start |=> busy_ff && t_ff == '0 && pre_ff == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timer did not restart");
endmodule // clt_pulse_gen

/* File: hdl/clt_timer.sv */
// camera trigger and light strobe cycle timer with axi4-lite registers
`include "clt_consts.svh"
module clt_timer #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // axi4-lite slave
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // trigger and run events
  input  wire logic          cycle_trig_in,
  input  wire logic          run_begin_in,
  input  wire logic          run_end_in,
  // camera and light
  output logic               cam_trig,
  output logic               light_strobe,
  output logic               run_active
);
  localparam int TW = `CLT_TW;
  localparam int LW = `CLT_LW;
  localparam int US = `CLT_US_CYC;

  logic              wr_en;
  logic [AW-1:0]     wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [AW-1:0]     rd_addr;
  logic [32:0]       rd_word;
  logic [32:0]       wr_old;
  logic [31:0]       wr_word;
  logic [4:0]        ctrl_ff;
  logic [TW-1:0]     trig_w_ff;
  logic [TW-1:0]     offset_ff;
  logic [TW-1:0]     light_w_ff;
  logic [TW-1:0]     min_sp_ff;
  logic [TW-1:0]     period_ff;
  logic [TW-1:0]     total_ff;
  logic [TW-1:0]     done_ff;
  logic [31:0]       lost_ff;
  clt_pkg::clt_seq_t seq_ff;
  clt_pkg::clt_seq_t nxt_seq;
  clt_pkg::clt_tmg_t tmg;
  logic [TW-1:0]     mag;
  logic [LW-1:0]     trig_end;
  logic [LW-1:0]     light_end;
  logic [LW-1:0]     need;
  logic [LW-1:0]     cyc_len;
  logic              pg_busy;
  logic              pg_end;
  logic              cmd_begin;
  logic              cmd_halt;
  logic              cmd_cycle;
  logic              lost_clr;
  logic              arm_rise;
  logic              halt_req;
  logic              trig_ev;
  logic              run_on;
  logic              avail;
  logic              cnt_done;
  logic              hold;
  logic              cyc_go;
  logic              stop_now;
  logic              lost;
  logic              begin_ev;
  logic [31:0]       gap_ff;
  logic              seen_ff;

  clt_axil_slave #(.AW(AW)) u_bus (
    .clk     (clk),
    .rstn    (rstn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_word[31:0]),
    .rd_err  (rd_word[32])
  );

  // bit 32 flags an unmapped address
  function automatic logic [32:0] reg_val(input logic [AW-1:0] a);
    case (a)
      AW'(`CLT_OFS_CTRL):    reg_val = {28'h0, ctrl_ff};
      AW'(`CLT_OFS_CMD):     reg_val = 33'h0;
      AW'(`CLT_OFS_TRIG_W):  reg_val = {9'h0, trig_w_ff};
      AW'(`CLT_OFS_OFFSET):  reg_val = {9'h0, offset_ff};
      AW'(`CLT_OFS_LIGHT_W): reg_val = {9'h0, light_w_ff};
      AW'(`CLT_OFS_MIN_SP):  reg_val = {9'h0, min_sp_ff};
      AW'(`CLT_OFS_PERIOD):  reg_val = {9'h0, period_ff};
      AW'(`CLT_OFS_TOTAL):   reg_val = {9'h0, total_ff};
      AW'(`CLT_OFS_STATUS):
        reg_val = {1'h0, done_ff, 5'h0, seq_ff[2], pg_busy, run_on};
      AW'(`CLT_OFS_LOST):    reg_val = {1'h0, lost_ff};
      AW'(`CLT_OFS_CYC_LEN): reg_val = {7'h0, cyc_len};
      default:               reg_val = {1'h1, 32'h0};
    endcase
  endfunction

  always_comb begin
    rd_word = reg_val(rd_addr);
    wr_old  = reg_val(wr_addr);
    wr_err  = wr_old[32];
    for (int i = 0; i < 4; i++) begin
      wr_word[i*8 +: 8] = wr_strb[i] ? wr_data[i*8 +: 8] : wr_old[i*8 +: 8];
    end
  end

  // command strobes, write-only
  assign cmd_begin = wr_en && wr_addr == AW'(`CLT_OFS_CMD) &&
                     wr_word[`CLT_CMD_BEGIN];
  assign cmd_halt  = wr_en && wr_addr == AW'(`CLT_OFS_CMD) &&
                     wr_word[`CLT_CMD_HALT];
  assign cmd_cycle = wr_en && wr_addr == AW'(`CLT_OFS_CMD) &&
                     wr_word[`CLT_CMD_CYCLE];
  assign lost_clr  = wr_en && wr_addr == AW'(`CLT_OFS_LOST);
  assign arm_rise  = wr_en && wr_addr == AW'(`CLT_OFS_CTRL) &&
                     wr_word[`CLT_CTRL_ARM] && !ctrl_ff[`CLT_CTRL_ARM];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff    <= `CLT_RST_CTRL;
      trig_w_ff  <= `CLT_RST_TRIG_W;
      offset_ff  <= `CLT_RST_OFFSET;
      light_w_ff <= `CLT_RST_LIGHT_W;
      min_sp_ff  <= `CLT_RST_MIN_SP;
      period_ff  <= `CLT_RST_PERIOD;
      total_ff   <= `CLT_RST_TOTAL;
    end else if (wr_en) begin
      case (wr_addr)
        AW'(`CLT_OFS_CTRL):    ctrl_ff    <= wr_word[4:0];
        AW'(`CLT_OFS_TRIG_W):  trig_w_ff  <= wr_word[TW-1:0];
        AW'(`CLT_OFS_OFFSET):  offset_ff  <= wr_word[TW-1:0];
        AW'(`CLT_OFS_LIGHT_W): light_w_ff <= wr_word[TW-1:0];
        AW'(`CLT_OFS_MIN_SP):  min_sp_ff  <= wr_word[TW-1:0];
        AW'(`CLT_OFS_PERIOD):  period_ff  <= wr_word[TW-1:0];
        AW'(`CLT_OFS_TOTAL):   total_ff   <= wr_word[TW-1:0];
        default:               ctrl_ff    <= ctrl_ff;
      endcase
    end
  end

  function automatic logic [LW-1:0] max2(input logic [LW-1:0] a,
                                         input logic [LW-1:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  // cycle length: least value meeting every constraint
  always_comb begin
    mag = offset_ff[TW-1] ? TW'(-offset_ff) : offset_ff;
    tmg.trig_delay  = offset_ff[TW-1] ? {2'h0, mag} : '0;
    tmg.light_delay = offset_ff[TW-1] ? '0 : {2'h0, mag};
    tmg.trig_width  = {2'h0, trig_w_ff};
    tmg.light_width = {2'h0, light_w_ff};
    // falling edges must land inside the cycle
    trig_end  = tmg.trig_delay + tmg.trig_width + LW'(1);
    light_end = tmg.light_delay + tmg.light_width + LW'(1);
    // without overlap the readout follows the exposure
    need = ctrl_ff[`CLT_CTRL_OVL] ? {2'h0, period_ff}
                                  : trig_end + {2'h0, period_ff};
    cyc_len = max2(max2({2'h0, min_sp_ff}, trig_end),
                   max2(light_end, need));
    tmg.cycle_len = cyc_len;
  end

  clt_pulse_gen u_pulse (
    .clk          (clk),
    .rstn         (rstn),
    .start        (cyc_go),
    .tmg_in       (tmg),
    .busy         (pg_busy),
    .cycle_end    (pg_end),
    .cam_trig     (cam_trig),
    .light_strobe (light_strobe)
  );

  // sequence and cycle trigger control
  always_comb begin
    halt_req = cmd_halt || run_end_in;
    trig_ev  = ctrl_ff[`CLT_CTRL_CYC_EXT] && (cycle_trig_in || cmd_cycle);
    run_on   = seq_ff != clt_pkg::CLT_IDLE;
    avail    = !pg_busy || pg_end;
    cnt_done = ctrl_ff[`CLT_CTRL_END_CNT] && done_ff >= total_ff;
    hold     = seq_ff == clt_pkg::CLT_STOPPING || halt_req || cnt_done;
    cyc_go   = run_on && avail && !hold &&
               (ctrl_ff[`CLT_CTRL_CYC_EXT] ? trig_ev : 1'b1);
    stop_now = run_on && avail && hold;
    lost     = trig_ev && !cyc_go;
    begin_ev = seq_ff == clt_pkg::CLT_IDLE &&
               (ctrl_ff[`CLT_CTRL_BEG_EXT] ? (cmd_begin || run_begin_in)
                                           : arm_rise);
  end

  always_comb begin
    case (seq_ff)
      clt_pkg::CLT_IDLE:
        nxt_seq = begin_ev ? clt_pkg::CLT_ACTIVE : clt_pkg::CLT_IDLE;
      clt_pkg::CLT_ACTIVE:
        if (stop_now) begin
          nxt_seq = clt_pkg::CLT_IDLE;
        end else if (halt_req) begin
          nxt_seq = clt_pkg::CLT_STOPPING;
        end else begin
          nxt_seq = clt_pkg::CLT_ACTIVE;
        end
      clt_pkg::CLT_STOPPING:
        nxt_seq = stop_now ? clt_pkg::CLT_IDLE : clt_pkg::CLT_STOPPING;
      default:
        nxt_seq = clt_pkg::CLT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_ff <= clt_pkg::CLT_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  assign run_active = seq_ff != clt_pkg::CLT_IDLE;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_ff <= '0;
    end else if (begin_ev) begin
      done_ff <= '0;
    end else if (cyc_go) begin
      done_ff <= done_ff + TW'(1);
    end
  end

  // a loss in the clearing cycle still counts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lost_ff <= '0;
    end else if (lost) begin
      lost_ff <= lost_clr ? 32'h1 : lost_ff + 32'h1;
    end else if (lost_clr) begin
      lost_ff <= '0;
    end
  end

  // helper for the spacing check
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_ff  <= '0;
      seen_ff <= 1'b0;
    end else if (cam_trig && !$past(cam_trig)) begin
      gap_ff  <= '0;
      seen_ff <= 1'b1;
    end else if (gap_ff != 32'hFFFFFFFF) begin
      gap_ff  <= gap_ff + 32'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_trig_rise;
    $rose(cam_trig) && seen_ff;
  endsequence

  property p_spacing;
    s_trig_rise |-> gap_ff + 32'h1 >= 32'(32'(min_sp_ff) * 32'(US));
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("trigger pulses too close");

  property p_len_least;
    cyc_len >= {2'h0, min_sp_ff} && cyc_len >= trig_end &&
    cyc_len >= light_end && cyc_len >= need &&
    (cyc_len == {2'h0, min_sp_ff} || cyc_len == trig_end ||
     cyc_len == light_end || cyc_len == need);
  endproperty
  a_len_least: assert property (p_len_least)
    else $error("cycle length not the least valid value");

  property p_idle_quiet;
    seq_ff == clt_pkg::CLT_IDLE |-> !pg_busy;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("cycle running outside a run");

  property p_count_end;
    run_on && cnt_done && avail |=> seq_ff == clt_pkg::CLT_IDLE;
  endproperty
  a_count_end: assert property (p_count_end)
    else $error("run did not end after its cycle count");

  property p_lost_count;
    trig_ev && !cyc_go && !lost_clr |=> lost_ff == $past(lost_ff) + 32'h1;
  endproperty
  a_lost_count: assert property (p_lost_count)
    else $error("rejected trigger not counted");
endmodule // clt_timer

/* File: testbench/clt_cam_model.sv */
// camera trigger input and strobe monitor
module clt_cam_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // pulses from the timer
  input  wire logic        cam_trig,
  input  wire logic        light_strobe,
  // width, rise gap, strobe lag
  output logic             done,
  output logic [35:0]      meas
);
  logic [11:0] pw_ff, gap_ff, lag_ff, g_ff, l_ff;
  logic        t_ff, s_ff;
  assign meas = {pw_ff, gap_ff, lag_ff};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {pw_ff, gap_ff, lag_ff} <= '0;
      {g_ff, l_ff} <= {12'hFFF, 12'hFFF};
      {t_ff, s_ff, done} <= '0;
    end else begin
      t_ff <= cam_trig;
      s_ff <= light_strobe;
      done <= t_ff & ~cam_trig;
      g_ff <= (cam_trig & ~t_ff) ? 12'h001 : g_ff + {11'h0, g_ff != 12'hFFF};
      l_ff <= (light_strobe & ~s_ff) ? 12'h001 : l_ff + {11'h0, &l_ff == 0};
      if (cam_trig) pw_ff <= t_ff ? pw_ff + 12'h001 : 12'h001;
      if (cam_trig & ~t_ff) begin
        gap_ff <= g_ff;
        lag_ff <= (light_strobe & ~s_ff) ? 12'h000 : l_ff;
      end
    end
  end
endmodule // clt_cam_model

/* File: testbench/clt_timer_tb.sv */
// self-checking bench for the camera light timer
module clt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, trig;
  logic        awready, wready, bvalid, arready, rvalid, done;
  logic        cam, strobe, run_act;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0]  wstrb;
  logic [1:0]  rresp, bresp;
  logic [1:0]  exp_b[$];
  logic [35:0] meas;
  logic [35:0] exp_p[$];
  logic [33:0] exp_r[$];
  int          n_errors, tests_run, cyc;
  int          t[5][4] = '{'{1,1,0,1}, '{1,5,-1,1}, '{0,4,2,1}, '{1,1,0,9},
                          '{1,1,0,0}};

  clt_timer u_dut (
    .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .cycle_trig_in(trig),
    .run_begin_in(1'b0), .run_end_in(1'b0), .cam_trig(cam),
    .light_strobe(strobe), .run_active(run_act)
  );
  clt_cam_model u_cam (
    .clk(clk), .rstn(rstn), .cam_trig(cam), .light_strobe(strobe),
    .done(done), .meas(meas)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic note(input logic ok, input logic [35:0] g, e);
    tests_run++;
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_p(input logic [35:0] g, e);
    note(g === e, g, e);
  endtask
  task automatic cmp_r(input logic [33:0] g, e);
    note(g === e, {2'h0, g}, {2'h0, e});
  endtask
  task automatic cmp_b(input logic [1:0] g, e);
    note(g === e, {34'h0, g}, {34'h0, e});
  endtask
  task automatic cmp_a(input logic g, e);
    note(g === e, {35'h0, g}, {35'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    exp_b.push_back((a > 8'h28 || a[1:0] != 2'h0) ? 2'h2 : 2'h0);
    @(posedge clk);
    {aw, w, b} = 3'b110;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!b) begin
      @(negedge clk);
      aw = aw && !awready;
      w = w && !wready;
      b = bvalid;
      @(posedge clk);
      {awvalid, wvalid, bready} <= {aw, w, !b};
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ar, r;
    @(posedge clk);
    {ar, r} = 2'b10;
    exp_r.push_back(e);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!r) begin
      @(negedge clk);
      ar = ar && !arready;
      r = rvalid;
      @(posedge clk);
      {arvalid, rready} <= {ar, !r};
    end
  endtask
  task automatic pulse;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask
  task automatic end_of_test;
    n_errors += exp_p.size() + exp_r.size() + exp_b.size();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (done) cmp_p(meas, exp_p.size() ? exp_p.pop_front() : '1);
    if (rvalid && rready) cmp_r({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready)
      cmp_b(bresp, exp_b.size() ? exp_b.pop_front() : 2'h3);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test;
    end
  end

  initial begin
    {rstn, trig, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    seed = 32'h2883;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 34'h2);
    rd(8'h08, 34'hA);
    rd(8'h40, {2'h2, 32'h0});
    wr(8'h40, 32'h1);
    wr(8'h08, 32'h2);
    wr(8'h10, 32'h1);
    for (int i = 0; i < 5; i++) begin
      int p, m, d, td, sd, l;
      logic [11:0] lg;
      p = t[i][1];
      d = t[i][2];
      td = (d < 0) ? -d : 0;
      sd = (d > 0) ? d : 0;
      m = t[i][3] ? t[i][3] : 1 + int'(seed % 32'hC);
      seed = lfsr(seed);
      l = (m > td + 3) ? m : td + 3;
      if (sd + 2 > l) l = sd + 2;
      if (t[i][0] == 0) p = p + td + 3;
      if (p > l) l = p;
      lg = (d > 0) ? 12'hFFF : 12'(td * 40);
      exp_p.push_back({12'h050, 12'hFFF, lg});
      lg = (d > 0) ? 12'((l - d) * 40) : lg;
      exp_p.push_back({12'h050, 12'(l * 40), lg});
      wr(8'h18, 32'(t[i][1]));
      wr(8'h14, 32'(m));
      wr(8'h0C, 32'(d) & 32'h00FFFFFF);
      wr(8'h1C, 32'h2);
      wr(8'h00, 32'h10 | 32'(t[i][0] * 2));
      wr(8'h00, 32'h11 | 32'(t[i][0] * 2));
      repeat (l * 80 + 200) @(posedge clk);
      rd(8'h28, 34'(l));
      rd(8'h20, 34'h200);
      repeat (4100) @(posedge clk);
    end
    wr(8'h24, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h06);
    pulse;
    wr(8'h00, 32'h07);
    @(negedge clk) cmp_a(run_act, 1'b1);
    exp_p.push_back({12'h050, 12'hFFF, 12'h000});
    exp_p.push_back({12'h050, 12'hFFF, 12'h000});
    wr(8'h04, 32'h4);
    pulse;
    repeat (4200) @(posedge clk);
    pulse;
    wr(8'h04, 32'h2);
    @(negedge clk) cmp_a(run_act, 1'b1);
    repeat (200) @(posedge clk);
    @(negedge clk) cmp_a(run_act, 1'b0);
    rd(8'h24, 34'h2);
    end_of_test;
  end
endmodule // clt_timer_tb
